// [src/apd_pkg.sv]
package pwr_down_pkg;
  localparam int IDLE_CNT_W = 4;
  localparam logic [3:0] IDLE_LIMIT = 4'hf;
  localparam int REG_A_AUTO_PD_BIT = 1;
  localparam int REG_A_SPEED_BIT = 3;
  localparam int REG_A_ARRAY_CLK_BIT = 4;
  localparam int REG_A_MCELL_CLK_BIT = 5;
  localparam int REG_B_WR_BIT = 2;
  localparam int REG_B_RD_BIT = 3;
  localparam int REG_B_PSE_BIT = 4;
  localparam int REG_B_ALE_BIT = 5;
  localparam int REG_B_SPARE_BIT = 6;
  localparam logic [7:0] REG_A_RESET = 8'h00;
  localparam logic [7:0] REG_B_RESET = 8'h00;
  localparam int REG_W = 8;
endpackage

// [src/sync2.sv]
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end
  assign o_q = sync_q;
endmodule // sync2

// [src/auto_powerdown_unit.sv]
`timescale 1ns/100ps
// Behaviour
// - Idle counter runs when enabled and strobe quiet
// - Fifteen idle clock periods raise power-down
// - Unit enable and chip select high enable power-down entry
// - Strobe activity ends power-down
// - Chip select low or reset high wakes
// - Bus blocked from memories and arrays
// - All memories deselected in power-down
// - Logic and PLD port pins stay active
// - Port pins: hold (MCU I/O), follow (PLD), or tri-state (peripheral)
// - Counter clock unaffected by array clock blocking
// - Logic clock feeds macrocells and counter
// - Chip select high disables memories and I/O space only
// - Register A bit 3 selects low-power speed
// - Register A bit 1 enables auto power-down
// - Bits 4,5 gate clock from array, macrocells
// - Register B bits 2-6 gate control inputs
module auto_powerdown_unit (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_logic_clock_in,
  input wire logic i_ale,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic i_program_store_enable_n,
  input wire logic i_chip_sel_n,
  input wire logic i_dev_reset,
  input wire logic i_reg_a_we,
  input wire logic i_reg_b_we,
  input wire logic [pwr_down_pkg::REG_W-1:0] i_reg_wdata,
  input wire logic [7:0] i_bus_ad,
  input wire logic [7:0] i_mcu_io_out,
  input wire logic [7:0] i_pld_out,
  input wire logic [7:0] i_periph_out,
  output logic [pwr_down_pkg::REG_W-1:0] o_power_mode_reg_a,
  output logic [pwr_down_pkg::REG_W-1:0] o_power_mode_reg_b,
  output logic o_powerdown_active,
  output logic [3:0] o_idle_count,
  output logic [7:0] o_mem_bus_ad,
  output logic o_mem_select,
  output logic o_io_space_enable,
  output logic o_array_bus_enable,
  output logic o_low_power_mode,
  output logic o_array_clk,
  output logic o_mcell_clk,
  output logic o_array_wr_n,
  output logic o_array_rd_n,
  output logic o_array_pse_n,
  output logic o_array_ale,
  output logic o_logic_active,
  output logic [7:0] o_mcu_io_pins,
  output logic [7:0] o_pld_pins,
  output logic [7:0] o_periph_pins,
  output logic o_periph_oe
);
  import pwr_down_pkg::*;

  logic [6:0] sync_out;
  logic clk_s, ale_s, wr_s, rd_s, pse_s, csn_s, rst_s;
  logic clk_prev_q, ale_prev_q;
  logic [REG_W-1:0] reg_a_q, reg_b_q;
  logic [IDLE_CNT_W-1:0] cnt_q, cnt_d;
  logic pd_q, pd_d;
  logic [7:0] bus_hold_q, bus_hold_d;
  logic [7:0] mcu_io_q, pld_q, periph_q;

  sync2 #(.W(7)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_d({i_logic_clock_in, i_ale, i_wr_n, i_rd_n, i_program_store_enable_n, i_chip_sel_n, i_dev_reset}),
    .o_q(sync_out)
  );
  assign {clk_s, ale_s, wr_s, rd_s, pse_s, csn_s, rst_s} = sync_out;

  // Rising edge of the logic clock drives the counter regardless of gating bits
  wire clk_rise = clk_s & ~clk_prev_q;
  wire ale_edge = ale_s ^ ale_prev_q;
  wire auto_en = reg_a_q[REG_A_AUTO_PD_BIT];
  wire wake = ale_edge | ~csn_s | rst_s;

  always_comb begin
    cnt_d = cnt_q;
    pd_d = pd_q;
    if (!auto_en || ale_edge || rst_s) begin
      cnt_d = '0;
    end else if (clk_rise && cnt_q != IDLE_LIMIT) begin
      cnt_d = cnt_q + 4'h1;
    end
    if (!auto_en || wake) begin
      pd_d = 1'b0;
    end else if (clk_rise && cnt_q == IDLE_LIMIT - 4'h1) begin
      pd_d = 1'b1;
    end
  end

  assign bus_hold_d = pd_q ? bus_hold_q : i_bus_ad;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_prev_q <= 1'b0;
      ale_prev_q <= 1'b0;
      cnt_q <= '0;
      pd_q <= 1'b0;
      bus_hold_q <= 8'h00;
    end else begin
      clk_prev_q <= clk_s;
      ale_prev_q <= ale_s;
      cnt_q <= cnt_d;
      pd_q <= pd_d;
      bus_hold_q <= bus_hold_d;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reg_a_q <= REG_A_RESET;
      reg_b_q <= REG_B_RESET;
    end else begin
      if (i_reg_a_we) begin
        reg_a_q <= i_reg_wdata;
      end
      if (i_reg_b_we) begin
        reg_b_q <= i_reg_wdata;
      end
    end
  end

  // Pins hold their last level in power-down where required
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mcu_io_q <= 8'h00;
      pld_q <= 8'h00;
      periph_q <= 8'h00;
    end else begin
      if (!pd_q) begin
        mcu_io_q <= i_mcu_io_out;
      end
      pld_q <= i_pld_out;
      periph_q <= i_periph_out;
    end
  end

  assign o_power_mode_reg_a = reg_a_q;
  assign o_power_mode_reg_b = reg_b_q;
  assign o_powerdown_active = pd_q;
  assign o_idle_count = cnt_q;
  assign o_mem_bus_ad = bus_hold_q;
  assign o_mem_select = ~pd_q & ~csn_s;
  assign o_io_space_enable = ~csn_s;
  assign o_array_bus_enable = ~pd_q;
  assign o_low_power_mode = reg_a_q[REG_A_SPEED_BIT];
  assign o_array_clk = clk_s & ~reg_a_q[REG_A_ARRAY_CLK_BIT];
  assign o_mcell_clk = clk_s & ~reg_a_q[REG_A_MCELL_CLK_BIT];
  assign o_array_wr_n = wr_s | reg_b_q[REG_B_WR_BIT];
  assign o_array_rd_n = rd_s | reg_b_q[REG_B_RD_BIT];
  assign o_array_pse_n = pse_s | reg_b_q[REG_B_PSE_BIT];
  assign o_array_ale = ale_s & ~reg_b_q[REG_B_ALE_BIT] & ~reg_b_q[REG_B_SPARE_BIT];
  assign o_logic_active = 1'b1;
  assign o_mcu_io_pins = mcu_io_q;
  assign o_pld_pins = pld_q;
  assign o_periph_pins = periph_q;
  assign o_periph_oe = ~pd_q;

  // Checks on counter, wake, pins and gating
  pd_entry_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (auto_en && !wake && clk_rise && cnt_q == 4'he) |=> pd_q) else $error("no power-down after idle");
  sequence wake_seq;
    pd_q && (ale_edge || !csn_s || rst_s);
  endsequence
  pd_exit_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    wake_seq |=> !pd_q) else $error("no wake on activity");
  cnt_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    ale_edge |=> cnt_q == 4'h0) else $error("counter not cleared");
  cnt_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (auto_en && !ale_edge && !rst_s && clk_rise && cnt_q < 4'hf) |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("counter did not step");
  cnt_sat_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (auto_en && !ale_edge && !rst_s && cnt_q == IDLE_LIMIT) |=> cnt_q == IDLE_LIMIT)
    else $error("counter left saturation");
  sequence dev_reset_seq;
    rst_s;
  endsequence
  rst_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    dev_reset_seq |=> !pd_q && cnt_q == 4'h0) else $error("reset pin did not clear");
  pd_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (pd_q && auto_en && !wake) |=> pd_q)
    else $error("power-down dropped without wake");
  cs_block_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !csn_s |=> !pd_q)
    else $error("power-down while chip selected");
  no_auto_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !auto_en |=> !pd_q) else $error("power-down while disabled");
  mem_desel_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    pd_q |-> !o_mem_select && !o_periph_oe) else $error("memory selected in power-down");
  bus_block_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    pd_q && $past(pd_q) |-> $stable(o_mem_bus_ad)) else $error("bus leaked in power-down");
  bus_pass_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (!$past(pd_q) && $past(i_arst_n)) |-> o_mem_bus_ad == $past(i_bus_ad))
    else $error("bus copy not updated");
  mcu_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    pd_q && $past(pd_q) |-> $stable(o_mcu_io_pins)) else $error("mcu pins changed in power-down");
  pld_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    $past(i_arst_n) |-> o_pld_pins == $past(i_pld_out)) else $error("logic pins frozen");
  cs_deselect_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    csn_s |-> !o_mem_select && !o_io_space_enable && o_array_bus_enable == !pd_q)
    else $error("chip select high misbehaved");
  clk_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    reg_a_q[REG_A_ARRAY_CLK_BIT] |-> !o_array_clk) else $error("array clock not gated");
  mcell_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    reg_a_q[REG_A_MCELL_CLK_BIT] |-> !o_mcell_clk) else $error("macrocell clock not gated");
  ctl_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    reg_b_q[REG_B_WR_BIT] |-> o_array_wr_n) else $error("write not gated");
  rd_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    reg_b_q[REG_B_RD_BIT] |-> o_array_rd_n) else $error("read not gated");
  pse_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    reg_b_q[REG_B_PSE_BIT] |-> o_array_pse_n) else $error("program store enable not gated");
  ale_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (reg_b_q[REG_B_ALE_BIT] || reg_b_q[REG_B_SPARE_BIT]) |-> !o_array_ale) else $error("strobe not gated");
endmodule // auto_powerdown_unit

// [verif/mcu_bus_model.sv]
`timescale 1ns/100ps
module mcu_bus_model (
  input wire logic i_clk_sys,
  input wire logic i_burst,
  output logic o_ale,
  output logic o_wr_n,
  output logic o_rd_n,
  output logic o_pse_n,
  output logic [7:0] o_bus_ad
);
  logic [2:0] ph_q = 3'h0;
  logic [7:0] ad_q = 8'h5a;
  // Bus changes every cycle, so a frozen internal copy stands out
  always @(posedge i_clk_sys) begin
    ad_q <= #1 ad_q + 8'h01;
    ph_q <= #1 (i_burst || ph_q != 3'h0) ? ph_q + 3'h1 : 3'h0;
  end
  assign o_bus_ad = ad_q;
  assign o_ale = ph_q == 3'h1;
  assign o_pse_n = ph_q != 3'h2;
  assign o_rd_n = ph_q != 3'h3;
  assign o_wr_n = ph_q != 3'h4;
endmodule // mcu_bus_model

// [verif/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic i_clk_sys = 0, i_arst_n = 0, i_logic_clock_in = 0, i_chip_sel_n = 1, i_dev_reset = 0;
  logic i_reg_a_we = 0, i_reg_b_we = 0, burst = 0, o_powerdown_active, o_mem_select, o_io_space_enable;
  logic i_ale, i_wr_n, i_rd_n, i_program_store_enable_n, o_array_bus_enable, o_low_power_mode, o_array_clk;
  logic o_mcell_clk, o_array_wr_n, o_array_rd_n, o_array_pse_n, o_array_ale, o_logic_active, o_periph_oe;
  logic [7:0] i_reg_wdata = 0, i_bus_ad, i_mcu_io_out = 8'h3c, i_pld_out = 8'h00, i_periph_out = 8'ha5;
  logic [7:0] o_power_mode_reg_a, o_power_mode_reg_b, o_mem_bus_ad, o_mcu_io_pins, o_pld_pins, o_periph_pins;
  logic [7:0] keep;
  logic [3:0] o_idle_count, act;
  int err_count = 0;
  int cmp_count = 0;
  auto_powerdown_unit i_dut (.i_clk_sys, .i_arst_n, .i_logic_clock_in, .i_ale, .i_wr_n, .i_rd_n,
    .i_program_store_enable_n, .i_chip_sel_n, .i_dev_reset, .i_reg_a_we, .i_reg_b_we, .i_reg_wdata,
    .i_bus_ad, .i_mcu_io_out, .i_pld_out, .i_periph_out, .o_power_mode_reg_a, .o_power_mode_reg_b,
    .o_powerdown_active, .o_idle_count, .o_mem_bus_ad, .o_mem_select, .o_io_space_enable,
    .o_array_bus_enable, .o_low_power_mode, .o_array_clk, .o_mcell_clk, .o_array_wr_n, .o_array_rd_n,
    .o_array_pse_n, .o_array_ale, .o_logic_active, .o_mcu_io_pins, .o_pld_pins, .o_periph_pins, .o_periph_oe);
  mcu_bus_model i_mcu (.i_clk_sys, .i_burst(burst), .o_ale(i_ale), .o_wr_n(i_wr_n), .o_rd_n(i_rd_n),
    .o_pse_n(i_program_store_enable_n), .o_bus_ad(i_bus_ad));
  initial begin
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic end_sim();
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] b);
    i_reg_wdata = a;
    i_reg_a_we = 1;
    cyc(1);
    i_reg_a_we = 0;
    i_reg_wdata = b;
    i_reg_b_we = 1;
    cyc(1);
    i_reg_b_we = 0;
    cyc(1);
  endtask
  task automatic edges(input int n);
    repeat (n) begin
      i_logic_clock_in = 1;
      cyc(4);
      i_logic_clock_in = 0;
      cyc(4);
    end
  endtask
  task automatic wait_pd(input logic v);
    int k;
    for (k = 0; k < 20 && o_powerdown_active !== v; k++) cyc(1);
    if (o_powerdown_active !== v) begin
      chk("pd_wait", {7'h0, o_powerdown_active}, {7'h0, v});
      end_sim();
    end
  endtask
  task automatic bus_burst(input logic [3:0] exp);
    act = 4'h0;
    burst = 1;
    cyc(1);
    burst = 0;
    repeat (12) begin
      act = act | {o_array_ale, ~o_array_wr_n, ~o_array_rd_n, ~o_array_pse_n};
      cyc(1);
    end
    chk("array_ctl", {4'h0, act}, {4'h0, exp});
  endtask
  task automatic s_regs();
    chk("reg_a", o_power_mode_reg_a, 8'h00);
    chk("reg_b", o_power_mode_reg_b, 8'h00);
    chk("low_pwr", {7'h0, o_low_power_mode}, 8'h00);
    wreg(8'h38, 8'h7c);
    chk("reg_a_wr", o_power_mode_reg_a, 8'h38);
    chk("reg_b_wr", o_power_mode_reg_b, 8'h7c);
    chk("low_pwr", {7'h0, o_low_power_mode}, 8'h01);
    i_logic_clock_in = 1;
    cyc(4);
    chk("clk_gate", {6'h0, o_array_clk, o_mcell_clk}, 8'h00);
    wreg(8'h00, 8'h00);
    chk("clk_pass", {6'h0, o_array_clk, o_mcell_clk}, 8'h03);
    i_logic_clock_in = 0;
    bus_burst(4'hf);
    wreg(8'h00, 8'h7c);
    bus_burst(4'h0);
  endtask
  task automatic s_pd();
    wreg(8'h32, 8'h00);
    edges(14);
    chk("cnt14", {3'h0, o_powerdown_active, o_idle_count}, 8'h0e);
    edges(1);
    chk("pd", {3'h0, o_powerdown_active, o_idle_count}, 8'h1f);
    chk("mem", {5'h0, o_mem_select, o_array_bus_enable, o_periph_oe}, 8'h00);
    keep = o_mem_bus_ad;
    i_mcu_io_out = 8'hc3;
    i_pld_out = 8'h99;
    i_periph_out = 8'h5a;
    cyc(4);
    chk("bus_frz", o_mem_bus_ad, keep);
    chk("periph", o_periph_pins, 8'h5a);
    chk("mcu_io", o_mcu_io_pins, 8'h3c);
    chk("pld", o_pld_pins, 8'h99);
    chk("active", {7'h0, o_logic_active}, 8'h01);
    burst = 1;
    cyc(1);
    burst = 0;
    wait_pd(0);
    chk("wake_ale", {4'h0, o_idle_count}, 8'h00);
    edges(15);
    wait_pd(1);
    i_dev_reset = 1;
    wait_pd(0);
    chk("wake_rst", {4'h0, o_idle_count}, 8'h00);
    i_dev_reset = 0;
    edges(15);
    wait_pd(1);
    i_chip_sel_n = 0;
    wait_pd(0);
    chk("wake_cs", {6'h0, o_powerdown_active, o_mem_select}, 8'h01);
  endtask
  task automatic s_cs();
    wreg(8'h00, 8'h00);
    cyc(3);
    chk("cs_low", {5'h0, o_mem_select, o_io_space_enable, o_array_bus_enable}, 8'h07);
    keep = o_mem_bus_ad;
    cyc(1);
    chk("bus_pass", o_mem_bus_ad, keep + 8'h01);
    i_chip_sel_n = 1;
    cyc(3);
    chk("cs_high", {5'h0, o_mem_select, o_io_space_enable, o_array_bus_enable}, 8'h01);
    edges(15);
    chk("no_auto", {3'h0, o_powerdown_active, o_idle_count}, 8'h00);
  endtask
  task automatic s_arst();
    wreg(8'h3a, 8'h7c);
    edges(15);
    wait_pd(1);
    i_arst_n = 0;
    cyc(2);
    chk("arst_pd", {3'h0, o_powerdown_active, o_idle_count}, 8'h00);
    chk("arst_a", o_power_mode_reg_a, 8'h00);
    chk("arst_b", o_power_mode_reg_b, 8'h00);
    i_arst_n = 1;
    cyc(3);
    chk("arst_speed", {7'h0, o_low_power_mode}, 8'h00);
  endtask
  initial begin
    cyc(12);
    i_arst_n = 1;
    cyc(3);
    s_regs();
    s_pd();
    s_cs();
    s_arst();
    end_sim();
  end
endmodule // tb_top
